// *** hdl/fs_cfg.svh ***
// Constants for the safety foot-switch monitor.
`ifndef FS_CFG_SVH
`define FS_CFG_SVH
`define FS_CLK_PERIOD_NS 50
`define FS_TICK_TIME_NS 100000000
`define FS_TICK_CYCLES (`FS_TICK_TIME_NS / `FS_CLK_PERIOD_NS)
`define FS_TICKS_PER_STEP 300
`define FS_LIMIT_MAX_STEPS 20
`define FS_LIMIT_OFF 5'h00
`define FS_MAX_UNITS 7
`define DIAG_WORD_OUT_NO_ENABLE 16'h0000
`define DIAG_WORD_OUT_WAITING 16'h2001
`define DIAG_WORD_OUT_REST 16'h2011
`define DIAG_WORD_OUT_PANIC 16'h2013
`define DIAG_WORD_OUT_UNDEFINED 16'h2014
`define DIAG_WORD_OUT_OPERATED 16'h8004
`define DIAG_WORD_OUT_TIMEOUT 16'hF002
`define DIAG_WORD_OUT_BAD_AFTER_EN 16'hF00F
`define DIAG_WORD_OUT_BAD_AFTER_PANIC 16'hF010
`endif

// *** hdl/fs_pkg.sv ***
// Types for the safety foot-switch monitor.
package fs_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_WAIT = 3'b001,
        ST_READY = 3'b011,
        ST_ON = 3'b010,
        ST_LOCK = 3'b110,
        ST_FAULT = 3'b111
    } fs_state_t;
    typedef enum logic [1:0] {
        POS_REST = 2'b00,
        POS_OPERATED = 2'b01,
        POS_PANIC = 2'b10,
        POS_UNDEF = 2'b11
    } fs_pos_t;
endpackage

// *** hdl/safety_foot_switch_monitor.sv ***
// Safety foot-switch monitor: enable contact, error contact, enable timer and diagnostics.
//
// Summary of operation
// - Limit active and exceeded withdraws the enable.
// - Without limit, enable holds while channels picked.
// - Limit is off or half-minute steps to ten minutes.
// - Limit setting defaults to off.
// - Option selects whether external enable is needed.
// - External enable defaults to not required.
// - Two or four channels, four by default.
// - Safety activation input arms the function.
// - Optional enable input switches whole function.
// - Enable closes only on correct pedal sequence.
// - Error contact closes on detected error.
// - Elapsed enable time is output.
// - Diagnostic word reports internal state.
// - Up to seven monitor instances supported.
// - Rest, armed, then operated closes; panic opens.
// - After return to rest enable stays open.
// - Errors acknowledged by return to rest or by the enable input going inactive.
// - Distinct diagnostic codes per state, except that ready shares the rest code.
`include "fs_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module safety_foot_switch_monitor
    import fs_pkg::*;
#(
    parameter int TICK_CYCLES = `FS_TICK_CYCLES,
    parameter int UNIT_INDEX = 1,
    parameter int TIME_WIDTH = 16
)
(
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic FOOT_CHANNEL_1,
    input wire logic FOOT_CHANNEL_2,
    input wire logic FOOT_CHANNEL_3,
    input wire logic FOOT_CHANNEL_4,
    input wire logic SAFETY_ARM_IN,
    input wire logic BLOCK_ENABLE_IN,
    input wire logic NO_EXTERNAL_ENABLE,
    input wire logic FOUR_CHANNEL_MODE,
    input wire logic [4:0] TIME_LIMIT_SETTING,
    output logic BRIDGE_ENABLE_OUT,
    output logic FAULT_OUT,
    output logic [TIME_WIDTH-1:0] ELAPSED_TIME_OUT,
    output logic [15:0] DIAG_WORD_OUT
);

    // Each instance serves one pedal; the relay places up to seven side by side.
    if (UNIT_INDEX < 1 || UNIT_INDEX > `FS_MAX_UNITS)
        $error("UNIT_INDEX out of range");
    if (TICK_CYCLES < 1)
        $error("TICK_CYCLES must be positive");
    if ((1 << TIME_WIDTH) <= `FS_LIMIT_MAX_STEPS * `FS_TICKS_PER_STEP)
        $error("TIME_WIDTH too small for longest limit");

    // Pins are synchronised; fill flags hold idle so cleared stages never read as a wire break.
    logic [3:0] chan_meta_reg;
    logic [3:0] chan_reg;
    logic [1:0] fill_reg;
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            chan_meta_reg <= 4'h0;
            chan_reg <= 4'h0;
            fill_reg <= '0;
        end
        else
        begin
            chan_meta_reg <= {FOOT_CHANNEL_4, FOOT_CHANNEL_3, FOOT_CHANNEL_2, FOOT_CHANNEL_1};
            chan_reg <= chan_meta_reg;
            fill_reg <= {fill_reg[0], 1'b1};
        end
    end

    // One make/break pair: make closes at operated, break opens at panic.
    function automatic fs_pos_t pair_pos(input logic make_c, input logic break_c);
        case ({make_c, break_c})
            2'b01: pair_pos = POS_REST;
            2'b11: pair_pos = POS_OPERATED;
            2'b10: pair_pos = POS_PANIC;
            default: pair_pos = POS_UNDEF;
        endcase
    endfunction

    // A broken wire, or in four-channel mode disagreeing pairs, decode as undefined.
    fs_pos_t pos_a;
    fs_pos_t pos_b;
    fs_pos_t pos;
    always_comb
    begin
        pos_a = pair_pos(chan_reg[0], chan_reg[1]);
        pos_b = pair_pos(chan_reg[2], chan_reg[3]);
        pos = pos_a;
        if (FOUR_CHANNEL_MODE && pos_a != pos_b)
            pos = POS_UNDEF;
    end

    // Zero means off; settings above ten minutes are clamped to ten.
    logic [4:0] steps;
    logic [TIME_WIDTH-1:0] limit_ticks;
    logic limit_on;
    always_comb
    begin
        steps = TIME_LIMIT_SETTING;
        if (steps > 5'(`FS_LIMIT_MAX_STEPS))
            steps = 5'(`FS_LIMIT_MAX_STEPS);
        limit_on = (steps != `FS_LIMIT_OFF);
        limit_ticks = TIME_WIDTH'(steps * `FS_TICKS_PER_STEP);
    end

    logic block_active;
    assign block_active = NO_EXTERNAL_ENABLE || BLOCK_ENABLE_IN;

    fs_state_t state_reg;
    fs_state_t state_next;
    logic [TIME_WIDTH-1:0] elapsed_reg;
    logic timed_out;
    assign timed_out = limit_on && (elapsed_reg > limit_ticks);

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE:
                state_next = fill_reg[1] ? ST_WAIT : ST_IDLE;
            ST_WAIT:
            begin
                if (pos == POS_UNDEF)
                    state_next = ST_FAULT;
                else if (pos == POS_REST && SAFETY_ARM_IN)
                    state_next = ST_READY;
            end
            ST_READY:
            begin
                if (pos == POS_UNDEF)
                    state_next = ST_FAULT;
                else if (!SAFETY_ARM_IN)
                    state_next = ST_WAIT;
                else if (pos == POS_OPERATED)
                    state_next = ST_ON;
                else if (pos == POS_PANIC)
                    state_next = ST_LOCK;
            end
            ST_ON:
            begin
                if (pos == POS_UNDEF || timed_out)
                    state_next = ST_FAULT;
                else if (pos == POS_PANIC || !SAFETY_ARM_IN)
                    state_next = ST_LOCK;
                else if (pos == POS_REST)
                    state_next = ST_WAIT;
            end
            ST_LOCK:
            begin
                if (pos == POS_REST)
                    state_next = ST_WAIT;
            end
            ST_FAULT:
            begin
                if (pos == POS_REST)
                    state_next = ST_WAIT;
            end
            default:
                state_next = ST_IDLE;
        endcase
        if (!block_active)
            state_next = ST_IDLE;
    end

    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
            state_reg <= ST_IDLE;
        else
            state_reg <= state_next;
    end

    // Remembers why the lock or fault state was entered, for the diagnostic word.
    logic panic_reg;
    logic timeout_reg;
    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            panic_reg <= 1'b0;
            timeout_reg <= 1'b0;
        end
        else
        begin
            if (state_next == ST_LOCK && state_reg != ST_LOCK)
                panic_reg <= (pos == POS_PANIC);
            if (state_next == ST_FAULT && state_reg != ST_FAULT)
                timeout_reg <= timed_out;
        end
    end

    // The time base ticks every tenth of a second while the contact is closed.
    logic [$clog2(TICK_CYCLES+1)-1:0] tick_cnt_reg;
    logic tick;
    assign tick = (tick_cnt_reg == ($bits(tick_cnt_reg))'(TICK_CYCLES - 1));
    always_ff @(posedge CLK)
    begin
        if (SYS_RST || state_reg != ST_ON)
            tick_cnt_reg <= '0;
        else if (tick)
            tick_cnt_reg <= '0;
        else
            tick_cnt_reg <= tick_cnt_reg + 1'b1;
    end

    // The count saturates so a long bridge without limit never wraps round.
    always_ff @(posedge CLK)
    begin
        if (SYS_RST || state_reg != ST_ON)
            elapsed_reg <= '0;
        else if (tick && elapsed_reg != '1)
            elapsed_reg <= elapsed_reg + 1'b1;
    end

    logic [15:0] diag;
    always_comb
    begin
        case (state_reg)
            ST_IDLE: diag = `DIAG_WORD_OUT_NO_ENABLE;
            ST_WAIT: diag = (pos == POS_REST) ? `DIAG_WORD_OUT_REST : `DIAG_WORD_OUT_WAITING;
            ST_READY: diag = `DIAG_WORD_OUT_REST;
            ST_ON: diag = `DIAG_WORD_OUT_OPERATED;
            ST_LOCK:
            begin
                if (pos == POS_PANIC)
                    diag = `DIAG_WORD_OUT_PANIC;
                else if (panic_reg)
                    diag = `DIAG_WORD_OUT_BAD_AFTER_PANIC;
                else
                    diag = `DIAG_WORD_OUT_BAD_AFTER_EN;
            end
            ST_FAULT: diag = timeout_reg ? `DIAG_WORD_OUT_TIMEOUT : `DIAG_WORD_OUT_UNDEFINED;
            default: diag = `DIAG_WORD_OUT_NO_ENABLE;
        endcase
    end

    always_ff @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            BRIDGE_ENABLE_OUT <= 1'b0;
            FAULT_OUT <= 1'b0;
            ELAPSED_TIME_OUT <= '0;
            DIAG_WORD_OUT <= `DIAG_WORD_OUT_NO_ENABLE;
        end
        else
        begin
            BRIDGE_ENABLE_OUT <= (state_next == ST_ON);
            FAULT_OUT <= (state_next == ST_FAULT);
            ELAPSED_TIME_OUT <= elapsed_reg;
            DIAG_WORD_OUT <= diag;
        end
    end

    property p_no_enable_when_inactive;
        @(posedge CLK) disable iff (SYS_RST) !block_active |=> !BRIDGE_ENABLE_OUT;
    endproperty
    a_no_enable_when_inactive: assert property (p_no_enable_when_inactive)
        else $error("enable closed while block inactive");

    property p_close_needs_ready;
        @(posedge CLK) disable iff (SYS_RST)
            $rose(BRIDGE_ENABLE_OUT) |-> $past(state_reg) == ST_READY && $past(SAFETY_ARM_IN);
    endproperty
    a_close_needs_ready: assert property (p_close_needs_ready)
        else $error("enable closed without rest and arm");

    property p_panic_opens;
        @(posedge CLK) disable iff (SYS_RST)
            state_reg == ST_ON && pos == POS_PANIC |=> !BRIDGE_ENABLE_OUT;
    endproperty
    a_panic_opens: assert property (p_panic_opens)
        else $error("panic did not open enable");

    property p_timeout_opens;
        @(posedge CLK) disable iff (SYS_RST)
            state_reg == ST_ON && timed_out && block_active |=> !BRIDGE_ENABLE_OUT && FAULT_OUT;
    endproperty
    a_timeout_opens: assert property (p_timeout_opens)
        else $error("timeout did not withdraw enable");

    property p_no_limit_holds;
        @(posedge CLK) disable iff (SYS_RST)
            state_reg == ST_ON && !limit_on && block_active && SAFETY_ARM_IN
            && pos == POS_OPERATED |=> BRIDGE_ENABLE_OUT;
    endproperty
    a_no_limit_holds: assert property (p_no_limit_holds)
        else $error("enable dropped without limit");

    property p_fault_held;
        @(posedge CLK) disable iff (SYS_RST)
            FAULT_OUT && pos != POS_REST && block_active |=> FAULT_OUT;
    endproperty
    a_fault_held: assert property (p_fault_held)
        else $error("fault cleared away from rest");

    property p_undef_open;
        @(posedge CLK) disable iff (SYS_RST) pos == POS_UNDEF |=> !BRIDGE_ENABLE_OUT;
    endproperty
    a_undef_open: assert property (p_undef_open)
        else $error("enable closed on undefined position");

    property p_timer_clears;
        @(posedge CLK) disable iff (SYS_RST) !BRIDGE_ENABLE_OUT |-> ##2 ELAPSED_TIME_OUT == '0;
    endproperty
    a_timer_clears: assert property (p_timer_clears)
        else $error("elapsed time not cleared");

    property p_diag_operated;
        @(posedge CLK) disable iff (SYS_RST)
            BRIDGE_ENABLE_OUT |=> DIAG_WORD_OUT == `DIAG_WORD_OUT_OPERATED;
    endproperty
    a_diag_operated: assert property (p_diag_operated)
        else $error("diagnostic word wrong while operated");

    property p_rest_no_close;
        @(posedge CLK) disable iff (SYS_RST) state_reg == ST_LOCK |=> !BRIDGE_ENABLE_OUT;
    endproperty
    a_rest_no_close: assert property (p_rest_no_close)
        else $error("enable closed from lock");

    c_enable: cover property (@(posedge CLK) disable iff (SYS_RST) $rose(BRIDGE_ENABLE_OUT));
    c_panic: cover property (@(posedge CLK) disable iff (SYS_RST)
        state_reg == ST_ON ##1 state_reg == ST_LOCK);
    c_timeout: cover property (@(posedge CLK) disable iff (SYS_RST)
        DIAG_WORD_OUT == `DIAG_WORD_OUT_TIMEOUT);
    c_ack: cover property (@(posedge CLK) disable iff (SYS_RST) $fell(FAULT_OUT));
endmodule
`default_nettype wire

// *** testbench/foot_switch_model.sv ***
// Behavioural model of a two-pair safety foot switch.
`timescale 1ns/1ps
`default_nettype none

module foot_switch_model
    import fs_pkg::*;
(
    input var fs_pos_t pos_a,
    input var fs_pos_t pos_b,
    output logic make_a,
    output logic break_a,
    output logic make_b,
    output logic break_b
);
    // Each pair reads {make, break}; a broken wire shows as both contacts open.
    function automatic logic [1:0] contacts(input fs_pos_t p);
        case (p)
            POS_REST: return 2'b01;
            POS_OPERATED: return 2'b11;
            POS_PANIC: return 2'b10;
            default: return 2'b00;
        endcase
    endfunction

    assign {make_a, break_a} = contacts(pos_a);
    assign {make_b, break_b} = contacts(pos_b);
endmodule

`default_nettype wire

// *** testbench/safety_foot_switch_monitor_tb_top.sv ***
// Self-checking bench for the safety foot-switch monitor.
`include "fs_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module safety_foot_switch_monitor_tb_top
    import fs_pkg::*;
;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    fs_pos_t pos_a = POS_REST;
    fs_pos_t pos_b = POS_REST;
    logic arm = 1'b1;
    logic blk_en = 1'b1;
    logic no_ext = 1'b1;
    logic four_ch = 1'b1;
    logic [4:0] limit = 5'h00;
    logic ch1, ch2, ch3, ch4, bridge, fault;
    logic [15:0] elapsed, diag;
    int err_count = 0;
    int checks = 0;

    always #25 clk = ~clk;

    foot_switch_model pedal (.pos_a(pos_a), .pos_b(pos_b), .make_a(ch1), .break_a(ch2),
        .make_b(ch3), .break_b(ch4));

    // A short tick keeps the half-minute limit within a few thousand cycles.
    safety_foot_switch_monitor #(.TICK_CYCLES(4), .UNIT_INDEX(1), .TIME_WIDTH(16)) DUT (
        .CLK(clk), .SYS_RST(sys_rst), .FOOT_CHANNEL_1(ch1), .FOOT_CHANNEL_2(ch2),
        .FOOT_CHANNEL_3(ch3), .FOOT_CHANNEL_4(ch4), .SAFETY_ARM_IN(arm),
        .BLOCK_ENABLE_IN(blk_en), .NO_EXTERNAL_ENABLE(no_ext), .FOUR_CHANNEL_MODE(four_ch),
        .TIME_LIMIT_SETTING(limit), .BRIDGE_ENABLE_OUT(bridge), .FAULT_OUT(fault),
        .ELAPSED_TIME_OUT(elapsed), .DIAG_WORD_OUT(diag));

    task automatic stop_test;
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_out(input logic b, input logic f, input logic [15:0] d);
        chk({15'h0000, bridge}, {15'h0000, b});
        chk({15'h0000, fault}, {15'h0000, f});
        chk(diag, d);
    endtask

    // Six cycles cover the synchroniser, the state update and the diagnostic lag.
    task automatic go(input fs_pos_t a, input fs_pos_t b);
        @(negedge clk);
        pos_a = a;
        pos_b = b;
        repeat (6) @(negedge clk);
    endtask

    task automatic test_reset;
        repeat (12) @(negedge clk);
        chk_out(1'b0, 1'b0, `DIAG_WORD_OUT_NO_ENABLE);
        chk(elapsed, 16'h0000);
        sys_rst = 1'b0;
        go(POS_REST, POS_REST);
        chk_out(1'b0, 1'b0, `DIAG_WORD_OUT_REST);
    endtask

    task automatic test_enable;
        go(POS_OPERATED, POS_OPERATED);
        chk_out(1'b1, 1'b0, `DIAG_WORD_OUT_OPERATED);
        repeat (40) @(negedge clk);
        chk({15'h0000, elapsed > 16'h0007}, 16'h0001);
        go(POS_REST, POS_REST);
        chk_out(1'b0, 1'b0, `DIAG_WORD_OUT_REST);
        chk(elapsed, 16'h0000);
    endtask

    task automatic test_panic;
        go(POS_OPERATED, POS_OPERATED);
        go(POS_PANIC, POS_PANIC);
        chk_out(1'b0, 1'b0, `DIAG_WORD_OUT_PANIC);
        go(POS_OPERATED, POS_OPERATED);
        chk_out(1'b0, 1'b0, `DIAG_WORD_OUT_BAD_AFTER_PANIC);
        go(POS_REST, POS_REST);
        chk_out(1'b0, 1'b0, `DIAG_WORD_OUT_REST);
    endtask

    task automatic test_arm;
        arm = 1'b0;
        go(POS_OPERATED, POS_OPERATED);
        chk_out(1'b0, 1'b0, `DIAG_WORD_OUT_WAITING);
        arm = 1'b1;
        go(POS_REST, POS_REST);
        go(POS_OPERATED, POS_OPERATED);
        arm = 1'b0;
        go(POS_OPERATED, POS_OPERATED);
        chk_out(1'b0, 1'b0, `DIAG_WORD_OUT_BAD_AFTER_EN);
        arm = 1'b1;
        go(POS_REST, POS_REST);
        chk_out(1'b0, 1'b0, `DIAG_WORD_OUT_REST);
    endtask

    task automatic test_ext;
        no_ext = 1'b0;
        blk_en = 1'b0;
        go(POS_OPERATED, POS_OPERATED);
        chk_out(1'b0, 1'b0, `DIAG_WORD_OUT_NO_ENABLE);
        go(POS_REST, POS_REST);
        blk_en = 1'b1;
        go(POS_OPERATED, POS_OPERATED);
        chk_out(1'b1, 1'b0, `DIAG_WORD_OUT_OPERATED);
        go(POS_REST, POS_REST);
        no_ext = 1'b1;
    endtask

    task automatic test_undef;
        go(POS_OPERATED, POS_REST);
        chk_out(1'b0, 1'b1, `DIAG_WORD_OUT_UNDEFINED);
        go(POS_REST, POS_REST);
        chk_out(1'b0, 1'b0, `DIAG_WORD_OUT_REST);
        four_ch = 1'b0;
        go(POS_OPERATED, POS_REST);
        chk_out(1'b1, 1'b0, `DIAG_WORD_OUT_OPERATED);
        go(POS_REST, POS_REST);
        four_ch = 1'b1;
    endtask

    // One step is 300 ticks of four cycles; the trip comes past tick 300.
    task automatic test_limit;
        limit = 5'h01;
        go(POS_OPERATED, POS_OPERATED);
        repeat (1150) @(negedge clk);
        chk_out(1'b1, 1'b0, `DIAG_WORD_OUT_OPERATED);
        repeat (100) @(negedge clk);
        chk_out(1'b0, 1'b1, `DIAG_WORD_OUT_TIMEOUT);
        go(POS_REST, POS_REST);
        chk_out(1'b0, 1'b0, `DIAG_WORD_OUT_REST);
        limit = `FS_LIMIT_OFF;
        go(POS_OPERATED, POS_OPERATED);
        repeat (1300) @(negedge clk);
        chk_out(1'b1, 1'b0, `DIAG_WORD_OUT_OPERATED);
        go(POS_REST, POS_REST);
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        err_count++;
        stop_test();
    end

    initial
    begin
        test_reset();
        test_enable();
        test_panic();
        test_arm();
        test_ext();
        test_undef();
        test_limit();
        stop_test();
    end
endmodule

`default_nettype wire
